//--- wdc_pkg.sv
// Constants, field layout and carrier types of the watchdog control block.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register port.
package wdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0]  OFS_CONTROL = 4'h0;
    localparam logic [3:0]  OFS_STATUS  = 4'h4;
    localparam logic [3:0]  OFS_MASK    = 4'h8;
    localparam logic [3:0]  OFS_COUNT   = 4'hc;

    localparam int unsigned KEY_MSB      = 31;
    localparam int unsigned KEY_LSB      = 16;
    localparam int unsigned ON_BIT       = 15;
    localparam int unsigned RUN_PS_MSB   = 12;
    localparam int unsigned RUN_PS_LSB   = 8;
    localparam int unsigned RUN_SRC_MSB  = 7;
    localparam int unsigned RUN_SRC_LSB  = 6;
    localparam int unsigned SLP_PS_MSB   = 5;
    localparam int unsigned SLP_PS_LSB   = 1;
    localparam int unsigned WIN_BIT      = 0;

    localparam logic [15:0] RESTART_KEY  = 16'h5743;
    localparam logic [3:0]  KEY_STROBE   = 4'hc;
    localparam logic        ON_RESET     = 1'h0;

    localparam int unsigned EV_TIMEOUT   = 0;
    localparam int unsigned EV_WIN_FAULT = 1;
    localparam int unsigned EV_COUNT     = 2;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       fuse_watchdog_enable;
        logic       fuse_window_disable;
        logic [4:0] fuse_run_postscale;
        logic [1:0] fuse_run_source;
        logic [4:0] fuse_sleep_postscale;
    } wdc_fuse_s;

endpackage

//--- wdc_top.sv
// Watchdog control register with its restart counter and AXI4-Lite slave.
// Assumes fuse values are stable around reset and inputs are synchronous to aclk.
`timescale 1ns/100ps

// Function
// - Single 16-bit key write restarts the count.
// - Key field is write-only, reads zero.
// - Enable bit 15 runs or stops watchdog.
// - Software enable matters only when fuse enable clear.
// - Bits 12:8 shadow run postscaler from fuse.
// - Bits 7:6 shadow run clock select.
// - Bits 5:1 shadow sleep postscaler from fuse.
// - Bit 0 window enable loads inverted fuse.
// - Bits 14:13 read zero, writes ignored.
module wdc_top #(
    parameter int unsigned TICK_DIV = wdc_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Fuse configuration and power mode.
    input  wire wdc_pkg::wdc_fuse_s    fuse,
    input  wire logic                  sleep_mode,
    // AXI4-Lite write channels.
    input  wire logic [3:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read channels.
    input  wire logic [3:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Watchdog results.
    output logic                       wdt_timeout,
    output logic                       irq
);
    import wdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic                  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic                  aw_got_q, w_got_q;
    logic [3:0]            waddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic [1:0]            bresp_q, rresp_q;
    logic [31:0]           rdata_q;
    logic                  on_q, win_q;
    logic [4:0]            run_ps_q, slp_ps_q;
    logic [1:0]            run_src_q;
    logic                  fuse_on_q;
    logic [EV_COUNT-1:0]   status_q, mask_q;
    logic [31:0]           count_q;
    logic [15:0]           tick_cnt_q;
    logic                  timeout_q, irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    wire                   aw_hs      = awvalid & awready_q;
    wire                   w_hs       = wvalid & wready_q;
    wire                   b_hs       = bvalid_q & bready;
    wire                   ar_hs      = arvalid & arready_q;
    wire                   r_hs       = rvalid_q & rready;
    wire                   do_write   = aw_got_q & w_got_q & ~bvalid_q;
    wire                   wr_ctrl    = do_write & (waddr_q == OFS_CONTROL);
    wire                   wr_status  = do_write & (waddr_q == OFS_STATUS);
    wire                   wr_mask    = do_write & (waddr_q == OFS_MASK);
    wire                   wr_mapped  = wr_ctrl | wr_status | wr_mask | (waddr_q == OFS_COUNT);
    wire                   rd_mapped  = (araddr[1:0] == 2'h0);
    // A full-word write is not a restart; the key must arrive as a half-word alone.
    wire                   key_write  = wr_ctrl & (wstrb_q == KEY_STROBE) &
                                        (wdata_q[KEY_MSB:KEY_LSB] == RESTART_KEY);
    wire                   wdt_run    = fuse_on_q | on_q;
    wire [4:0]             active_ps  = sleep_mode ? slp_ps_q : run_ps_q;
    wire [31:0]            period     = 32'h1 << active_ps;
    wire [31:0]            win_open   = period - (period >> 2);
    wire                   tick       = (tick_cnt_q == 16'(TICK_DIV - 1));
    wire                   expire     = wdt_run & tick & (count_q >= period - 32'h1);
    wire                   early_clr  = key_write & wdt_run & win_q &
                                        (count_q < win_open);
    wire [EV_COUNT-1:0]    events     = {early_clr, expire};
    wire [EV_COUNT-1:0]    clr_bits   = (wr_status & wstrb_q[0]) ? wdata_q[EV_COUNT-1:0]
                                                                 : '0;
    // Key and unimplemented bits are never stored, so they always read as zero.
    wire [31:0]            ctrl_rd    = {16'h0, on_q, 2'h0, run_ps_q, run_src_q,
                                         slp_ps_q, win_q};
    wire [31:0]            rd_value   = (araddr == OFS_CONTROL) ? ctrl_rd :
                                        (araddr == OFS_STATUS)  ? 32'(status_q) :
                                        (araddr == OFS_MASK)    ? 32'(mask_q) :
                                                                  count_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'h0;
            wready_q  <= 1'h0;
            aw_got_q  <= 1'h0;
            w_got_q   <= 1'h0;
            waddr_q   <= 4'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'h0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                waddr_q   <= awaddr;
                aw_got_q  <= 1'h1;
            end
            if (w_hs) begin
                wdata_q   <= wdata;
                wstrb_q   <= wstrb;
                w_got_q   <= 1'h1;
            end
            awready_q <= ~aw_got_q & ~aw_hs & ~bvalid_q & ~do_write;
            wready_q  <= ~w_got_q & ~w_hs & ~bvalid_q & ~do_write;
            if (do_write) begin
                aw_got_q <= 1'h0;
                w_got_q  <= 1'h0;
                bvalid_q <= 1'h1;
                bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (b_hs) begin
                bvalid_q <= 1'h0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'h0;
            rvalid_q  <= 1'h0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_q & ~ar_hs;
            if (ar_hs) begin
                rvalid_q <= 1'h1;
                rdata_q  <= rd_mapped ? rd_value : 32'h0;
                rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (r_hs) begin
                rvalid_q <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The reset is synchronous, so the shadows may take the fuse levels in the reset branch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_q      <= ON_RESET;
            fuse_on_q <= fuse.fuse_watchdog_enable;
            run_ps_q  <= fuse.fuse_run_postscale;
            run_src_q <= fuse.fuse_run_source;
            slp_ps_q  <= fuse.fuse_sleep_postscale;
            win_q     <= ~fuse.fuse_window_disable;
        end else if (wr_ctrl) begin
            if (wstrb_q[1]) begin
                on_q <= wdata_q[ON_BIT];
            end
            if (wstrb_q[0]) begin
                win_q <= wdata_q[WIN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn || !wdt_run || key_write) begin
            tick_cnt_q <= 16'h0;
            count_q    <= 32'h0;
        end else if (tick) begin
            tick_cnt_q <= 16'h0;
            count_q    <= expire ? 32'h0 : count_q + 32'h1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h1;
        end
    end

    // A new event in the same cycle as a write-one clear keeps its bit set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q  <= '0;
            mask_q    <= '0;
            timeout_q <= 1'h0;
            irq_q     <= 1'h0;
        end else begin
            status_q  <= (status_q & ~clr_bits) | events;
            if (wr_mask && wstrb_q[0]) begin
                mask_q <= wdata_q[EV_COUNT-1:0];
            end
            timeout_q <= expire | early_clr;
            irq_q     <= |(((status_q & ~clr_bits) | events) & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign awready     = awready_q;
    assign wready      = wready_q;
    assign bvalid      = bvalid_q;
    assign bresp       = bresp_q;
    assign arready     = arready_q;
    assign rvalid      = rvalid_q;
    assign rdata       = rdata_q;
    assign rresp       = rresp_q;
    assign wdt_timeout = timeout_q;
    assign irq         = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_key_restart_count: assert property (
        key_write |=> (count_q == 32'h0)
    ) else $error("Count not restarted by the key write.");

    a_key_reads_zero: assert property (
        ar_hs && araddr == OFS_CONTROL |=> rvalid_q && rdata_q[31:16] == 16'h0
    ) else $error("Key field read back nonzero.");

    a_disabled_holds_count: assert property (
        !wdt_run |=> (count_q == 32'h0) && !timeout_q
    ) else $error("Disabled watchdog still counts.");

    a_fuse_overrides_on: assert property (
        fuse_on_q && !on_q && tick && !expire && !key_write
        |=> count_q == $past(count_q) + 32'h1
    ) else $error("Fuse enable did not keep the count running.");

    a_shadow_run_ps: assert property (
        $rose(aresetn) |-> run_ps_q == $past(fuse.fuse_run_postscale)
    ) else $error("Run postscaler shadow not loaded at reset.");

    a_shadow_run_src: assert property (
        $rose(aresetn) |-> run_src_q == $past(fuse.fuse_run_source) ##1 $stable(run_src_q)
    ) else $error("Run clock select shadow wrong.");

    a_shadow_sleep_ps: assert property (
        $rose(aresetn) |-> slp_ps_q == $past(fuse.fuse_sleep_postscale)
    ) else $error("Sleep postscaler shadow not loaded at reset.");

    a_window_reset_load: assert property (
        $rose(aresetn) |-> win_q == !$past(fuse.fuse_window_disable)
    ) else $error("Window enable not loaded from the inverted fuse bit.");

    a_gap_bits_zero: assert property (
        ar_hs && araddr == OFS_CONTROL |=> rdata_q[14:13] == 2'h0
    ) else $error("Unimplemented control bits read nonzero.");

    a_event_to_irq: assert property (
        (expire || early_clr) |=> timeout_q && status_q != '0 ##0
            (irq_q == |(status_q & $past(mask_q)))
    ) else $error("Watchdog event did not reach status and interrupt.");

    a_timeout_sets_flag: assert property (
        expire |=> status_q[EV_TIMEOUT]
    ) else $error("Timeout did not set its status flag.");

    a_fault_sets_flag: assert property (
        early_clr |=> status_q[EV_WIN_FAULT]
    ) else $error("Early windowed clear did not set its status flag.");

    a_status_w1c: assert property (
        wr_status && wstrb_q[0] && wdata_q[EV_TIMEOUT] && !expire |=> !status_q[EV_TIMEOUT]
    ) else $error("Write-one did not clear the timeout flag.");

    a_mask_write: assert property (
        wr_mask && wstrb_q[0] |=> mask_q == $past(wdata_q[EV_COUNT-1:0])
    ) else $error("Mask register did not take the written value.");

    a_plain_write_keeps: assert property (
        wr_ctrl && !key_write && wdt_run && !tick
        |=> count_q == $past(count_q) && tick_cnt_q == $past(tick_cnt_q) + 16'h1
    ) else $error("Control write without the key restarted the count.");

    a_key_keeps_ctrl: assert property (
        key_write |=> on_q == $past(on_q) && win_q == $past(win_q)
    ) else $error("Key write altered the enable or window bit.");

    a_count_read: assert property (
        ar_hs && araddr == OFS_COUNT |=> rdata_q == $past(count_q)
    ) else $error("Count read returned a stale value.");

    a_read_slverr: assert property (
        ar_hs && araddr[1:0] != 2'h0 |=> rresp_q == RESP_SLVERR && rdata_q == 32'h0
    ) else $error("Unaligned read not refused.");

    a_ready_after_reset: assert property (
        $rose(aresetn) |-> !bvalid_q && !rvalid_q ##1 awready_q && wready_q && arready_q
    ) else $error("Bus did not come ready after reset.");

    c_key_restart: cover property (key_write && wdt_run);
    c_timeout:     cover property (expire);
    c_early_clear: cover property (early_clr);
    c_fuse_forced: cover property (fuse_on_q && !on_q && expire);
    c_irq_raised:  cover property (!irq_q ##1 irq_q);
endmodule

//--- tb_top.sv
// Self-checking bench for the watchdog control block, driven over AXI4-Lite.
// Assumes the design package and top module are compiled first; clock and reset come from here.
`timescale 1ns/100ps

module tb_top;
    import wdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CYC_LIMIT = 20000;

    logic        aclk;
    logic        aresetn;
    wdc_fuse_s   fuse;
    logic        sleep_mode;
    logic [3:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        wdt_timeout;
    logic        irq;
    int          err_total;
    int          checked;
    int          pulses;
    int          p0;
    int          cyc;
    logic [31:0] rd;
    logic [1:0]  rsp;
    wdc_fuse_s   fa;
    wdc_fuse_s   fb;

    // A two-cycle tick keeps each run postscaled period down to 8 or 16 cycles; the sleep periods stay far longer.
    wdc_top #(.TICK_DIV(2)) wdc_top_i (
        .aclk(aclk), .aresetn(aresetn), .fuse(fuse), .sleep_mode(sleep_mode),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wdt_timeout(wdt_timeout), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (wdt_timeout === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cyc == CYC_LIMIT) begin
            err_total++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Each task begins one edge later so no signal is assigned twice in a time step.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic do_reset(input wdc_fuse_s f);
        @(posedge aclk);
        fuse <= f;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    function automatic logic [31:0] ctl(input logic on, input logic win, input wdc_fuse_s f);
        ctl = {16'h0000, on, 2'h0, f.fuse_run_postscale, f.fuse_run_source,
               f.fuse_sleep_postscale, win};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, sleep_mode} = '0;
        {err_total, checked, pulses, cyc} = '0;
        aresetn = 1'b0;
        fa = {1'h0, 1'h0, 5'h03, 2'h2, 5'h15};
        fb = {1'h1, 1'h1, 5'h02, 2'h1, 5'h0a};
        fuse = fa;
        do_reset(fa);
        axi_read(OFS_CONTROL);
        chk("ctl reset", ctl(1'b0, 1'b1, fa), rd);
        axi_write(OFS_CONTROL, 32'hffff_ffff, 4'h3);
        chk("ctl wr resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        axi_read(OFS_CONTROL);
        chk("ctl on win", ctl(1'b1, 1'b1, fa), rd);
        axi_write(OFS_CONTROL, {RESTART_KEY, 16'h0000}, KEY_STROBE);
        axi_read(OFS_STATUS);
        chk("early clear", 32'h2, rd & 32'h2);
        axi_write(OFS_CONTROL, 32'h0000_8000, 4'h3);
        axi_write(OFS_STATUS, 32'h3, 4'hf);
        p0 = pulses;
        repeat (8) begin
            axi_write(OFS_CONTROL, {RESTART_KEY, 16'h0000}, KEY_STROBE);
            repeat (4) @(posedge aclk);
        end
        chk("keyed pulses", 32'h0, pulses - p0);
        axi_read(OFS_CONTROL);
        chk("key reads 0", ctl(1'b1, 1'b0, fa), rd);
        p0 = pulses;
        repeat (8) begin
            axi_write(OFS_CONTROL, {RESTART_KEY + 16'h0001, 16'h0000}, KEY_STROBE);
            repeat (4) @(posedge aclk);
        end
        chk("bad key fires", 32'h1, {31'h0, pulses > p0});
        axi_write(OFS_MASK, 32'h1, 4'hf);
        repeat (40) @(posedge aclk);
        chk("irq set", 32'h1, {31'h0, irq});
        axi_read(OFS_STATUS);
        chk("timeout flag", 32'h1, rd & 32'h1);
        axi_write(OFS_CONTROL, 32'h0, 4'h3);
        axi_write(OFS_STATUS, 32'h3, 4'hf);
        repeat (3) @(posedge aclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        p0 = pulses;
        repeat (60) @(posedge aclk);
        chk("stopped", 32'h0, pulses - p0);
        axi_read(OFS_COUNT);
        chk("count stopped", 32'h0, rd);
        axi_read(4'h1);
        chk("unaligned rd", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        // Fuse enable forces the watchdog on with the software bit still clear.
        do_reset(fb);
        axi_read(OFS_CONTROL);
        chk("ctl fuse b", ctl(1'b0, 1'b0, fb), rd);
        p0 = pulses;
        repeat (40) @(posedge aclk);
        chk("fuse runs", 32'h1, {31'h0, pulses > p0});
        // The sleep postscaler gives a period far beyond the wait, so no pulse may come.
        @(posedge aclk);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        p0 = pulses;
        repeat (60) @(posedge aclk);
        chk("sleep period", 32'h0, pulses - p0);
        print_verdict();
    end

endmodule
